// >>> rtl/udfc_pkg.sv
// shared constants for the unknown-destination forwarding control block
package udfc_pkg;
  localparam int unsigned NPORTS = 6;
  // register indices; one word each, so the byte address is four times the index
  localparam logic [11:0] IDX_LUT_INDEX = 12'h31a;
  localparam logic [11:0] IDX_UCAST     = 12'h320;
  localparam logic [11:0] IDX_MCAST     = 12'h324;
  localparam logic [11:0] IDX_VLAN      = 12'h328;
  localparam logic [11:0] IDX_MACCTL0   = 12'h330;
  localparam logic [11:0] OFS_LUT_INDEX = {IDX_LUT_INDEX[9:0], 2'b00};
  localparam logic [11:0] OFS_UCAST     = {IDX_UCAST[9:0], 2'b00};
  localparam logic [11:0] OFS_MCAST     = {IDX_MCAST[9:0], 2'b00};
  localparam logic [11:0] OFS_VLAN      = {IDX_VLAN[9:0], 2'b00};
  localparam logic [11:0] OFS_MACCTL0   = {IDX_MACCTL0[9:0], 2'b00};
  localparam int unsigned LUT_IDX_W     = 10;
  localparam int unsigned FWD_EN_BIT    = 31;
  localparam int unsigned MC0_ALT_BO    = 7;
  localparam int unsigned MC0_LEN_CHK   = 3;
  localparam int unsigned MC0_RSVD2     = 2;
  localparam int unsigned MC0_FC_DROP   = 1;
  localparam int unsigned MC0_AGGR_BO   = 0;
  localparam logic [7:0]  MC0_RESET     = 8'h04;
  localparam logic [7:0]  MC0_WMASK     = 8'hff;
  localparam logic [15:0] LEN_LIMIT     = 16'd1500;
  localparam logic [15:0] ETYPE_FLOWCTL = 16'h8808;
  localparam logic [47:0] DA_PAUSE      = 48'h0180c2000001;
  typedef enum logic [1:0] {UDFC_CAT_NONE, UDFC_CAT_VID, UDFC_CAT_UCAST, UDFC_CAT_MCAST} udfc_cat_t;
endpackage

// >>> rtl/udfc_top.sv
// register bank and decision logic for unknown-destination forwarding and mac control 0
// Summary of operation
// - every external table access latches its bucket address into a read-only 10-bit index.
// - a packet in several unknown categories uses only vid, else unicast, else multicast control.
// - unknown unicast goes to masked ports only while unicast enable bit 31 is set.
// - the 6-bit unicast mask bit n selects port n+1; all ones all ports, zeros none.
// - unknown multicast goes to masked ports only while multicast enable bit 31 is set.
// - the 6-bit multicast mask bit n selects port n+1; all ones all ports, zeros none.
// - unknown vid goes to masked ports only while vid enable bit 31 is set.
// - the 6-bit vid mask bit n selects port n+1; all ones all ports, zeros none.
// - mac control 0 bit 7 enables alternate back-off, applied to half-duplex ports only.
// - with bit 3 set a packet whose length field is below 1500 and mismatches is discarded.
// - with drop mode bit 1 set a packet is dropped on flow-control ethertype or pause da.
// - with drop mode bit 1 clear a packet is dropped only on both ethertype and pause da.
// - mac control 0 bit 0 enables aggressive back-off for half-duplex back pressure.
`timescale 1ns/1ps
module udfc_top #(
  parameter int unsigned NP = udfc_pkg::NPORTS
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // lookup table access from engine
  input  wire logic              i_lut_access,
  input  wire logic [9:0]        i_lut_bucket,
  // packet classification
  input  wire logic              i_pkt_valid,
  input  wire logic              i_unk_vid,
  input  wire logic              i_unk_ucast,
  input  wire logic              i_unk_mcast,
  input  wire logic [15:0]       i_etype_len,
  input  wire logic [15:0]       i_payload_len,
  input  wire logic [47:0]       i_da,
  input  wire logic [NP-1:0]     i_half_duplex,
  // decisions
  output logic                   o_dec_valid,
  output logic [NP-1:0]          o_fwd_ports,
  output logic                   o_fwd_hit,
  output logic                   o_drop_len,
  output logic                   o_drop_fc,
  output logic [NP-1:0]          o_alt_backoff,
  output logic [NP-1:0]          o_aggr_backoff
);
  logic [9:0]    lut_idx_q;
  logic          uc_en_q, mc_en_q, vid_en_q;
  logic [NP-1:0] uc_ports_q, mc_ports_q, vid_ports_q;
  logic [7:0]    mc0_q;
  logic          wr_acc, rd_acc;
  logic [31:0]   rd_d;
  udfc_pkg::udfc_cat_t cat;
  logic [NP-1:0] ports_d;
  logic          hit_d, fc_et, fc_da, len_bad;

  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;

  // one wait-free access phase, ready registered off the setup cycle
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_pready <= 1'b0;
    else
      o_pready <= i_psel && !i_penable;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      lut_idx_q <= 10'h000;
    else if (i_lut_access)
      lut_idx_q <= i_lut_bucket;
  end

  // writes land at the edge where pready is sampled high
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      uc_en_q     <= 1'b0;
      mc_en_q     <= 1'b0;
      vid_en_q    <= 1'b0;
      uc_ports_q  <= '0;
      mc_ports_q  <= '0;
      vid_ports_q <= '0;
      mc0_q       <= udfc_pkg::MC0_RESET;
    end
    else if (wr_acc && o_pready)
    begin
      case (i_paddr)
        udfc_pkg::OFS_UCAST:
        begin
          if (i_pstrb[3]) uc_en_q <= i_pwdata[udfc_pkg::FWD_EN_BIT];
          if (i_pstrb[0]) uc_ports_q <= i_pwdata[NP-1:0];
        end
        udfc_pkg::OFS_MCAST:
        begin
          if (i_pstrb[3]) mc_en_q <= i_pwdata[udfc_pkg::FWD_EN_BIT];
          if (i_pstrb[0]) mc_ports_q <= i_pwdata[NP-1:0];
        end
        udfc_pkg::OFS_VLAN:
        begin
          if (i_pstrb[3]) vid_en_q <= i_pwdata[udfc_pkg::FWD_EN_BIT];
          if (i_pstrb[0]) vid_ports_q <= i_pwdata[NP-1:0];
        end
        udfc_pkg::OFS_MACCTL0:
        begin
          if (i_pstrb[0]) mc0_q <= i_pwdata[7:0] & udfc_pkg::MC0_WMASK;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (i_paddr)
      udfc_pkg::OFS_LUT_INDEX: rd_d[9:0] = lut_idx_q;
      udfc_pkg::OFS_UCAST:     rd_d = {uc_en_q, {(31-NP){1'b0}}, uc_ports_q};
      udfc_pkg::OFS_MCAST:     rd_d = {mc_en_q, {(31-NP){1'b0}}, mc_ports_q};
      udfc_pkg::OFS_VLAN:      rd_d = {vid_en_q, {(31-NP){1'b0}}, vid_ports_q};
      udfc_pkg::OFS_MACCTL0:   rd_d[7:0] = mc0_q;
      default:                 rd_d = 32'h0000_0000;
    endcase
  end

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == udfc_pkg::OFS_LUT_INDEX) || (a == udfc_pkg::OFS_UCAST) ||
             (a == udfc_pkg::OFS_MCAST) || (a == udfc_pkg::OFS_VLAN) ||
             (a == udfc_pkg::OFS_MACCTL0);
  endfunction

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_d;
      // read-only index rejects writes; unmapped answers error
      o_pslverr <= !mapped(i_paddr) || (i_pwrite && i_paddr == udfc_pkg::OFS_LUT_INDEX);
    end
  end

  // category precedence: vid, then unicast, then multicast
  always_comb
  begin
    if (i_unk_vid)
      cat = udfc_pkg::UDFC_CAT_VID;
    else if (i_unk_ucast)
      cat = udfc_pkg::UDFC_CAT_UCAST;
    else if (i_unk_mcast)
      cat = udfc_pkg::UDFC_CAT_MCAST;
    else
      cat = udfc_pkg::UDFC_CAT_NONE;
    case (cat)
      udfc_pkg::UDFC_CAT_VID:
      begin
        hit_d   = 1'b1;
        ports_d = vid_en_q ? vid_ports_q : '0;
      end
      udfc_pkg::UDFC_CAT_UCAST:
      begin
        hit_d   = 1'b1;
        ports_d = uc_en_q ? uc_ports_q : '0;
      end
      udfc_pkg::UDFC_CAT_MCAST:
      begin
        hit_d   = 1'b1;
        ports_d = mc_en_q ? mc_ports_q : '0;
      end
      default:
      begin
        hit_d   = 1'b0;
        ports_d = '0;
      end
    endcase
  end

  assign fc_et   = (i_etype_len == udfc_pkg::ETYPE_FLOWCTL);
  assign fc_da   = (i_da == udfc_pkg::DA_PAUSE);
  assign len_bad = (i_etype_len < udfc_pkg::LEN_LIMIT) && (i_etype_len != i_payload_len);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_dec_valid <= 1'b0;
      o_fwd_ports <= '0;
      o_fwd_hit   <= 1'b0;
      o_drop_len  <= 1'b0;
      o_drop_fc   <= 1'b0;
    end
    else
    begin
      o_dec_valid <= i_pkt_valid;
      o_fwd_ports <= i_pkt_valid ? ports_d : '0;
      o_fwd_hit   <= i_pkt_valid && hit_d;
      o_drop_len  <= i_pkt_valid && mc0_q[udfc_pkg::MC0_LEN_CHK] && len_bad;
      if (mc0_q[udfc_pkg::MC0_FC_DROP])
        o_drop_fc <= i_pkt_valid && (fc_et || fc_da);
      else
        o_drop_fc <= i_pkt_valid && fc_et && fc_da;
    end
  end

  // back-off modes only reach half-duplex ports; is left to software
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_alt_backoff  <= '0;
      o_aggr_backoff <= '0;
    end
    else
    begin
      o_alt_backoff  <= {NP{mc0_q[udfc_pkg::MC0_ALT_BO]}} & i_half_duplex;
      o_aggr_backoff <= {NP{mc0_q[udfc_pkg::MC0_AGGR_BO]}} & i_half_duplex;
    end
  end

  property p_lut_idx;
    @(posedge i_clk) disable iff (!i_resetn)
    i_lut_access |=> lut_idx_q == $past(i_lut_bucket);
  endproperty
  a_lut_idx: assert property (p_lut_idx) else $error("lookup index not captured");

  property p_prec_vid;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && i_unk_vid) |=> o_fwd_ports == ($past(vid_en_q) ? $past(vid_ports_q) : '0);
  endproperty
  a_prec_vid: assert property (p_prec_vid) else $error("vid precedence broken");

  property p_ucast;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !i_unk_vid && i_unk_ucast) |=>
      o_fwd_ports == ($past(uc_en_q) ? $past(uc_ports_q) : '0);
  endproperty
  a_ucast: assert property (p_ucast) else $error("unicast ports wrong");

  property p_mcast;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !i_unk_vid && !i_unk_ucast && i_unk_mcast) |=>
      o_fwd_ports == ($past(mc_en_q) ? $past(mc_ports_q) : '0);
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast ports wrong");

  property p_disabled;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && i_unk_vid && !vid_en_q) |=> o_fwd_ports == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled vid forwarded");

  property p_len;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !mc0_q[udfc_pkg::MC0_LEN_CHK]) |=> !o_drop_len;
  endproperty
  a_len: assert property (p_len) else $error("length drop without check");

  property p_fc_or;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && mc0_q[udfc_pkg::MC0_FC_DROP] && (fc_et || fc_da)) |=> o_drop_fc;
  endproperty
  a_fc_or: assert property (p_fc_or) else $error("flow-control drop missed");

  property p_fc_and;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !mc0_q[udfc_pkg::MC0_FC_DROP] && !(fc_et && fc_da)) |=> !o_drop_fc;
  endproperty
  a_fc_and: assert property (p_fc_and) else $error("flow-control drop too eager");

  property p_alt;
    @(posedge i_clk) disable iff (!i_resetn)
    ##1 o_alt_backoff == ({NP{$past(mc0_q[udfc_pkg::MC0_ALT_BO])}} & $past(i_half_duplex));
  endproperty
  a_alt: assert property (p_alt) else $error("alternate back-off wrong");

  property p_aggr;
    @(posedge i_clk) disable iff (!i_resetn)
    ##1 o_aggr_backoff == ({NP{$past(mc0_q[udfc_pkg::MC0_AGGR_BO])}} & $past(i_half_duplex));
  endproperty
  a_aggr: assert property (p_aggr) else $error("aggressive back-off wrong");

  // index only moves on a table access; bus writes must not touch it
  property p_idx_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    !i_lut_access |=> $stable(lut_idx_q);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("lookup index moved");

  property p_ro_err;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_psel && !i_penable && i_pwrite && (i_paddr == udfc_pkg::OFS_LUT_INDEX)) |=> o_pslverr;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("index write not refused");

  property p_pready_pulse;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_psel && !i_penable) |=> o_pready ##1 !o_pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready not one cycle");

  property p_dec_idle;
    @(posedge i_clk) disable iff (!i_resetn)
    !i_pkt_valid |=> !o_dec_valid && !o_fwd_hit && !(|o_fwd_ports) && !o_drop_len && !o_drop_fc;
  endproperty
  a_dec_idle: assert property (p_dec_idle) else $error("decision outputs not idle");

  property p_uc_all;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !i_unk_vid && i_unk_ucast && uc_en_q && (&uc_ports_q)) |=> (&o_fwd_ports);
  endproperty
  a_uc_all: assert property (p_uc_all) else $error("unicast all-ones mask missed");

  property p_mc_all;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && !i_unk_vid && !i_unk_ucast && i_unk_mcast && mc_en_q && (&mc_ports_q)) |=>
      (&o_fwd_ports);
  endproperty
  a_mc_all: assert property (p_mc_all) else $error("multicast all-ones mask missed");

  property p_vid_none;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pkt_valid && i_unk_vid && !(|vid_ports_q)) |=> !(|o_fwd_ports);
  endproperty
  a_vid_none: assert property (p_vid_none) else $error("vid empty mask forwarded");

  c_wr: cover property (@(posedge i_clk) wr_acc && o_pready);
  c_rd: cover property (@(posedge i_clk) rd_acc && o_pready);
  c_multi: cover property (@(posedge i_clk) i_pkt_valid && i_unk_vid && i_unk_ucast);
  c_fc: cover property (@(posedge i_clk) o_drop_fc);
endmodule // udfc_top

// >>> test/test_udfc_top.sv
// self-checking bench for the unknown-destination forwarding control block
`timescale 1ns/1ps
module test_udfc_top;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0]  i_pstrb = 4'hf;
  logic        i_lut_access = 1'b0;
  logic [9:0]  i_lut_bucket = 10'h0;
  logic        i_pkt_valid = 1'b0;
  logic [2:0]  unk = 3'h0;
  logic [15:0] i_etype_len = 16'h0;
  logic [15:0] i_payload_len = 16'h0;
  logic [47:0] i_da = 48'h0;
  logic [5:0]  i_half_duplex = 6'h0;
  logic        o_pready, o_pslverr, o_dec_valid, o_fwd_hit, o_drop_len, o_drop_fc;
  logic [31:0] o_prdata;
  logic [5:0]  o_fwd_ports, o_alt_backoff, o_aggr_backoff;
  // model: ucast, mcast, vid, mac ctl0
  logic [31:0] m_reg [4] = '{32'h0, 32'h0, 32'h0, 32'(udfc_pkg::MC0_RESET)};
  logic [11:0] ofs [4] = '{udfc_pkg::OFS_UCAST, udfc_pkg::OFS_MCAST, udfc_pkg::OFS_VLAN,
                           udfc_pkg::OFS_MACCTL0};
  logic [31:0] wmask [4] = '{32'h8000003f, 32'h8000003f, 32'h8000003f, 32'h000000ff};
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;

  udfc_top udfc_top_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_lut_access(i_lut_access), .i_lut_bucket(i_lut_bucket), .i_pkt_valid(i_pkt_valid),
    .i_unk_vid(unk[2]), .i_unk_ucast(unk[1]), .i_unk_mcast(unk[0]),
    .i_etype_len(i_etype_len), .i_payload_len(i_payload_len), .i_da(i_da),
    .i_half_duplex(i_half_duplex), .o_dec_valid(o_dec_valid), .o_fwd_ports(o_fwd_ports),
    .o_fwd_hit(o_fwd_hit), .o_drop_len(o_drop_len), .o_drop_fc(o_drop_fc),
    .o_alt_backoff(o_alt_backoff), .o_aggr_backoff(o_aggr_backoff)
  );

  always #50 i_clk = ~i_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hung handshake ends up here instead of spinning forever
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(eexp));
  endtask

  task automatic wr(input int k, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ofs[k], d, rd, err);
    m_reg[k] = d & wmask[k];
    chk(32'(err), 32'h0);
  endtask

  task automatic pkt();
    logic [31:0] sel;
    logic [15:0] pl;
    logic [15:0] et;
    logic [47:0] da;
    logic [5:0]  hd;
    logic [2:0]  f;
    logic        fe;
    logic        fd;
    f = 3'($urandom);
    hd = 6'($urandom);
    pl = 16'($urandom_range(1600));
    case ($urandom_range(3))
      0: et = udfc_pkg::ETYPE_FLOWCTL;
      1: et = pl;
      2: et = udfc_pkg::LEN_LIMIT - 16'($urandom_range(1));
      default: et = 16'($urandom);
    endcase
    // at most one bit away from the pause address
    da = udfc_pkg::DA_PAUSE ^ (48'($urandom_range(1)) << $urandom_range(47));
    @(posedge i_clk);
    i_pkt_valid <= 1'b1;
    unk <= f;
    i_etype_len <= et;
    i_payload_len <= pl;
    i_da <= da;
    i_half_duplex <= hd;
    @(posedge i_clk);
    i_pkt_valid <= 1'b0;
    sel = f[2] ? m_reg[2] : (f[1] ? m_reg[0] : m_reg[1]);
    fe = (et == udfc_pkg::ETYPE_FLOWCTL);
    fd = (da == udfc_pkg::DA_PAUSE);
    #1;
    chk(32'(o_dec_valid), 32'h1);
    chk(32'(o_fwd_hit), 32'(|f));
    chk(32'(o_fwd_ports), (|f && sel[31]) ? 32'(sel[5:0]) : 32'h0);
    chk(32'(o_drop_len), 32'(m_reg[3][3] && et < 16'd1500 && et != pl));
    chk(32'(o_drop_fc), 32'(m_reg[3][1] ? (fe || fd) : (fe && fd)));
    chk(32'(o_alt_backoff), 32'({6{m_reg[3][7]}} & hd));
    chk(32'(o_aggr_backoff), 32'({6{m_reg[3][0]}} & hd));
  endtask

  initial
  begin
    logic [31:0] rd;
    logic        err;
    logic [9:0]  b;
    rd = $urandom(1748);
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int k = 0; k < 4; k++)
      rd_chk(ofs[k], m_reg[k], 1'b0);
    rd_chk(udfc_pkg::OFS_LUT_INDEX, 32'h0, 1'b0);
    rd_chk(12'h31c, 32'h0, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < 4; k++)
      begin
        // all-ones pass sets alt back-off, as software must before enabling no-drop
        wr(k, (i == 0) ? 32'hffffffff : ((i == 1) ? 32'h0 : $urandom));
        rd_chk(ofs[k], m_reg[k], 1'b0);
      end
    $display("test register access done");
    repeat (4)
    begin
      b = 10'($urandom);
      @(posedge i_clk);
      i_lut_access <= 1'b1;
      i_lut_bucket <= ~b;
      @(posedge i_clk);
      i_lut_bucket <= b;
      @(posedge i_clk);
      i_lut_access <= 1'b0;
      apb(1'b1, udfc_pkg::OFS_LUT_INDEX, 32'hffffffff, rd, err);
      chk(32'(err), 32'h1);
      rd_chk(udfc_pkg::OFS_LUT_INDEX, 32'(b), 1'b0);
    end
    $display("test table index done");
    // first round opens every mask fully, second enables empty masks
    for (int r = 0; r < 30; r++)
    begin
      for (int k = 0; k < 4; k++)
        wr(k, (r == 0) ? 32'hffffffff : ((r == 1) ? 32'h80000000 : $urandom));
      repeat (10) pkt();
    end
    $display("test packet decisions done");
    summarize();
  end
endmodule // test_udfc_top
